// [smfc_cfg.svh]
/*
  Constants for the supervisor, mute and fault control block.
  Assumes inclusion by smfc_top.sv only, not by smfc_pkg.sv; definitions only.
*/
`ifndef SMFC_CFG_SVH
`define SMFC_CFG_SVH
`define SMFC_CLK_HZ        250000000
`define SMFC_PWM_HZ        425000
`define SMFC_PWM_DIV       (`SMFC_CLK_HZ / `SMFC_PWM_HZ)
`define SMFC_LL_COUNT      2048
`define SMFC_MUTE_EDGES    10
`define SMFC_DEGLITCH_NS   16000
`define SMFC_CLK_NS        4
`define SMFC_DEGLITCH_CYC  ((`SMFC_DEGLITCH_NS + `SMFC_CLK_NS - 1) / `SMFC_CLK_NS)
`define SMFC_UPPER_CLR     15
`define SMFC_BLANK_CYC     25
`endif

// [smfc_pkg.sv]
/*
  Types for the supervisor, mute and fault control block.
  Assumes nothing beyond the constants header.
*/
package smfc_pkg;
  typedef enum logic [1:0] {
    SMFC_MUTE_IDLE = 2'b01,
    SMFC_MUTE_HOLD = 2'b10
  } smfc_mute_t;
endpackage

// [smfc_top.sv]
/*
  Supervisor, mute and fault control for a four-output regulator.
  Assumes comparator outputs arrive asynchronously from the analog side
  and the host drives the enable pins; open-drain pins resolved outside.
*/
`timescale 1ns/10ps
`include "smfc_cfg.svh"
`default_nettype none
module smfc_top
  import smfc_pkg::*;
#(
  parameter int PWM_DIV      = `SMFC_PWM_DIV,
  parameter int LL_COUNT     = `SMFC_LL_COUNT,
  parameter int DEGLITCH_CYC = `SMFC_DEGLITCH_CYC,
  parameter int BLANK_CYC    = `SMFC_BLANK_CYC
)
(
  input  wire logic clk,                   // System clock, 250 MHz
  input  wire logic rst_b,                 // Async reset, active low
  input  wire logic switch_enable_in,      // Host switch enable
  input  wire logic enable_sync_in,        // Host enable/sync
  input  wire logic accessory_sense_in,    // Accessory comparator
  input  wire logic backup_sense_in,       // Backup comparator raw
  input  wire logic mute_timer_pin,        // Timer pin above threshold
  input  wire logic switch_supply_ov,      // Switch supply overvoltage
  input  wire logic feedback_two_fault,    // Feedback two under/over
  input  wire logic feedback_three_fault,  // Feedback three under/over
  input  wire logic feedback_four_fault,   // Feedback four under/over
  input  wire logic feedback_one_fault,    // Feedback one, not used for power-good
  input  wire logic buck_one_uvlo,         // Buck one supply lockout
  input  wire logic buck_two_uvlo,         // Buck two supply lockout
  input  wire logic buck_three_uvlo,       // Buck three supply lockout
  input  wire logic thermal_low,           // Lower thermal comparator
  input  wire logic thermal_high,          // Upper thermal comparator
  input  wire logic upper_current_over,    // Upper switch current over limit
  output logic      high_side_switch_one,  // Switch one on
  output logic      high_side_switch_two,  // Switch two on
  output logic      buck_one_en,           // Buck one enable
  output logic      buck_two_en,           // Buck two enable
  output logic      buck_three_en,         // Buck three enable
  output logic      buck_four_en,          // Buck four enable
  output logic      light_load_mode,       // Buck one light-load mode
  output logic      pwm_gate_on,           // Upper switch gate drive
  output logic      backup_compare_out,    // Filtered backup level
  output logic      mute_oe,               // Mute pin pulled low
  output logic      power_good_oe,         // Power-good pin pulled low
  output logic      thermal_warn_latch,    // Lower thermal latch
  output logic      thermal_shutdown_latch // Upper thermal latch
);
  localparam int NSYNC = 13;
  localparam int DIVW  = $clog2(PWM_DIV + 1);
  localparam int LLW   = $clog2(LL_COUNT + 1);
  localparam int DGW   = $clog2(DEGLITCH_CYC + 1);
  localparam int BLW   = $clog2(BLANK_CYC + 1);

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  logic             ens_s, ensync_s, acc_s, bu_s, mute_timer_pin_s, ov_s, fb2_s, fb3_s, fb4_s;
  logic             uv1_s, uv2_s, tl_s, th_s, oc_s;
  logic [DIVW-1:0]  div_reg;
  logic             tick_reg;
  logic [LLW-1:0]   ll_cnt_reg;
  logic [DGW-1:0]   dg_cnt_reg;
  logic             bu_filt_reg;
  logic             bu_change;
  logic             mute_timer_pin_prev_reg;
  logic [3:0]       mute_cnt_reg;
  smfc_mute_t       mute_state_reg;
  logic [3:0]       upper_clr_reg;
  logic [BLW-1:0]   blank_reg;
  logic             pulse_on_reg;
  logic             uv3_s;

  // Feedback one is deliberately not collected here
  assign async_in = {buck_three_uvlo, upper_current_over, thermal_high, thermal_low, buck_two_uvlo,
                     buck_one_uvlo, feedback_four_fault, feedback_three_fault, feedback_two_fault,
                     switch_supply_ov, mute_timer_pin, backup_sense_in,
                     accessory_sense_in ^ 1'b0} ;
  assign {uv3_s, oc_s, th_s, tl_s, uv2_s, uv1_s, fb4_s, fb3_s, fb2_s, ov_s, mute_timer_pin_s, bu_s, acc_s} = sync_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  // Enable pins also come from another chip
  logic [1:0] en_meta_reg;
  logic [1:0] en_sync_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_meta_reg <= '0;
      en_sync_reg <= '0;
    end
    else
    begin
      en_meta_reg <= {switch_enable_in, enable_sync_in};
      en_sync_reg <= en_meta_reg;
    end
  end
  assign {ens_s, ensync_s} = en_sync_reg;

  // Oscillator tick; sync frequency scaling is outside this block
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (div_reg == DIVW'(PWM_DIV - 1))
    begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      div_reg  <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // Light-load selection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ll_cnt_reg      <= '0;
      light_load_mode <= 1'b0;
    end
    else if (acc_s)
    begin
      ll_cnt_reg      <= '0;
      light_load_mode <= thermal_shutdown_latch;
    end
    else if (ensync_s)
    begin
      ll_cnt_reg      <= '0;
      light_load_mode <= thermal_shutdown_latch;
    end
    else if (tick_reg)
    begin
      if (ll_cnt_reg == LLW'(LL_COUNT - 1))
        light_load_mode <= 1'b1;
      else
      begin
        ll_cnt_reg      <= ll_cnt_reg + 1'b1;
        // A tick must not delay the forced light load by a cycle
        light_load_mode <= light_load_mode || thermal_shutdown_latch;
      end
    end
    else if (thermal_shutdown_latch)
      light_load_mode <= 1'b1;
  end

  // Deglitch: a new level must hold for the full window
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dg_cnt_reg  <= '0;
      bu_filt_reg <= 1'b0;
    end
    else if (bu_s == bu_filt_reg)
      dg_cnt_reg <= '0;
    else if (dg_cnt_reg == DGW'(DEGLITCH_CYC - 1))
    begin
      dg_cnt_reg  <= '0;
      bu_filt_reg <= bu_s;
    end
    else
      dg_cnt_reg <= dg_cnt_reg + 1'b1;
  end
  assign bu_change = (bu_s != bu_filt_reg) && (dg_cnt_reg == DGW'(DEGLITCH_CYC - 1));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      backup_compare_out <= 1'b0;
    else
      backup_compare_out <= bu_filt_reg;
  end

  // Mute sequencer; thermal inputs are not read here
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mute_state_reg <= SMFC_MUTE_IDLE;
      mute_cnt_reg   <= '0;
      mute_timer_pin_prev_reg  <= 1'b0;
      mute_oe        <= 1'b0;
    end
    else
    begin
      mute_timer_pin_prev_reg <= mute_timer_pin_s;
      unique case (mute_state_reg)
        SMFC_MUTE_IDLE:
        begin
          if (bu_change)
          begin
            mute_state_reg <= SMFC_MUTE_HOLD;
            mute_cnt_reg   <= '0;
            mute_oe        <= 1'b1;
          end
        end
        SMFC_MUTE_HOLD:
        begin
          if (bu_change)
            mute_cnt_reg <= '0;
          else if (mute_timer_pin_s != mute_timer_pin_prev_reg)
          begin
            if (mute_cnt_reg == 4'(`SMFC_MUTE_EDGES - 1))
            begin
              mute_state_reg <= SMFC_MUTE_IDLE;
              mute_oe        <= 1'b0;
            end
            else
              mute_cnt_reg <= mute_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Thermal latches; set wins over clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      thermal_warn_latch     <= 1'b0;
      thermal_shutdown_latch <= 1'b0;
      upper_clr_reg          <= '0;
    end
    else
    begin
      if (tl_s && !th_s)
        thermal_warn_latch <= 1'b1;
      else if (!ens_s && !tl_s)
        thermal_warn_latch <= 1'b0;
      if (ensync_s)
        upper_clr_reg <= '0;
      else if (tick_reg && upper_clr_reg != 4'(`SMFC_UPPER_CLR))
        upper_clr_reg <= upper_clr_reg + 1'b1;
      if (th_s)
        thermal_shutdown_latch <= 1'b1;
      else if (upper_clr_reg == 4'(`SMFC_UPPER_CLR) || uv1_s)
        thermal_shutdown_latch <= 1'b0;
    end
  end

  // Enables, switches and power-good
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      high_side_switch_one <= 1'b0;
      high_side_switch_two <= 1'b0;
      buck_one_en          <= 1'b0;
      buck_two_en          <= 1'b0;
      buck_three_en        <= 1'b0;
      buck_four_en         <= 1'b0;
      power_good_oe        <= 1'b1;
    end
    else
    begin
      high_side_switch_one <= ens_s && !ov_s && !thermal_warn_latch && !thermal_shutdown_latch;
      high_side_switch_two <= ens_s && !ov_s && !thermal_warn_latch && !thermal_shutdown_latch;
      buck_one_en          <= !uv1_s;
      buck_two_en          <= ensync_s && !uv2_s && !thermal_shutdown_latch;
      buck_three_en        <= ensync_s && !uv3_s && !thermal_shutdown_latch;
      buck_four_en         <= ensync_s && !thermal_shutdown_latch;
      power_good_oe        <= fb2_s || fb3_s || fb4_s;
    end
  end

  // Pulse-by-pulse limit, no enable term so nothing can switch it off
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pulse_on_reg <= 1'b0;
      blank_reg    <= '0;
      pwm_gate_on  <= 1'b0;
    end
    else
    begin
      if (tick_reg)
      begin
        pulse_on_reg <= 1'b1;
        blank_reg    <= BLW'(BLANK_CYC);
      end
      else
      begin
        if (blank_reg != '0)
          blank_reg <= blank_reg - 1'b1;
        if (oc_s && blank_reg == '0)
          pulse_on_reg <= 1'b0;
      end
      pwm_gate_on <= pulse_on_reg && !(oc_s && blank_reg == '0);
    end
  end
endmodule
`default_nettype wire

// [smfc_top_sva.sv]
/* Assertions on the smfc_top ports.
   Assumes a bind onto smfc_top and one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module smfc_chk #(
  parameter int PWM_DIV  = 4,
  parameter int LL_COUNT = 8
)
(
  input wire logic clk,                    // Clock
  input wire logic rst_b,                  // Reset
  input wire logic enable_sync_in,         // Enable/sync
  input wire logic accessory_sense_in,     // Accessory
  input wire logic switch_supply_ov,       // Overvoltage
  input wire logic feedback_two_fault,     // Feedback two
  input wire logic buck_one_uvlo,          // Lockout one
  input wire logic thermal_high,           // Upper thermal
  input wire logic high_side_switch_one,   // Switch one
  input wire logic high_side_switch_two,   // Switch two
  input wire logic buck_one_en,            // Buck one
  input wire logic light_load_mode,        // Light load
  input wire logic backup_compare_out,     // Filtered backup
  input wire logic mute_oe,                // Mute
  input wire logic power_good_oe,          // Power-good
  input wire logic thermal_warn_latch,     // Lower latch
  input wire logic thermal_shutdown_latch  // Upper latch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int low_cnt;
  // Cycles with both light-load causes low, to bound early entry
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      low_cnt <= 0;
    else if (accessory_sense_in || enable_sync_in)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  AST_SW_PAIR: assert property (high_side_switch_one == high_side_switch_two)
    else $error("switches differ");
  AST_OV_OFF: assert property (switch_supply_ov[*6] |-> !high_side_switch_one)
    else $error("switch on in overvoltage");
  AST_LL_MIN: assert property ($rose(light_load_mode) && !thermal_shutdown_latch |-> low_cnt >= (LL_COUNT - 1) * PWM_DIV)
    else $error("light load too early");
  AST_ACC_EXIT: assert property ((accessory_sense_in && !thermal_high && !thermal_shutdown_latch)[*6] |-> !light_load_mode)
    else $error("light load with accessory");
  AST_MUTE_BACKUP: assert property ($changed(backup_compare_out) |-> ##[0:2] mute_oe)
    else $error("no mute on backup change");
  AST_PG_FAULT: assert property (feedback_two_fault[*6] |-> power_good_oe)
    else $error("power-good not pulled low");
  AST_UVLO: assert property (buck_one_uvlo[*6] |-> !buck_one_en)
    else $error("buck one on in lockout");
  AST_WARN_OFF: assert property (thermal_warn_latch[*2] |-> !high_side_switch_one)
    else $error("switch on under warn latch");
  AST_HI_LATCH: assert property (thermal_shutdown_latch[*2] |-> !high_side_switch_one && light_load_mode)
    else $error("shutdown latch not obeyed");
  cover property ($rose(mute_oe));
  cover property ($rose(light_load_mode));
  cover property ($rose(thermal_shutdown_latch));
endmodule
`default_nettype wire

// [smfc_timer_model.sv]
/* Mute timer capacitor seen through its threshold comparator.
   Assumes the bench clock; HALF sets cycles between transitions. */
`timescale 1ns/10ps
`default_nettype none
module smfc_timer_model #(
  parameter int HALF = 3
)
(
  input  wire logic clk,            // Clock
  input  wire logic rst_b,          // Reset
  input  wire logic mute_oe,        // Mute held
  output logic      mute_timer_pin  // Comparator
);
  int cnt;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cnt <= 0;
    else if (!mute_oe || cnt == HALF - 1)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  // Capacitor only swings while mute is held, resting low otherwise
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      mute_timer_pin <= 1'b0;
    else if (!mute_oe)
      mute_timer_pin <= 1'b0;
    else if (cnt == HALF - 1)
      mute_timer_pin <= ~mute_timer_pin;
endmodule
`default_nettype wire

// [test_smfc_top.sv]
/* Self-checking bench for smfc_top with a mute timer model.
   Assumes short parameters so all counts finish quickly. */
`timescale 1ns/10ps
`default_nettype none
bind smfc_top smfc_chk #(.PWM_DIV(PWM_DIV), .LL_COUNT(LL_COUNT)) smfc_chk_inst (.*);
module test_smfc_top;
  typedef struct {string n; logic [10:0] m; logic [10:0] v;} smfc_note_t;
  logic clk, rst_b, switch_enable_in, enable_sync_in, accessory_sense_in, backup_sense_in, mute_timer_pin;
  logic switch_supply_ov, feedback_one_fault, feedback_two_fault, feedback_three_fault, feedback_four_fault;
  logic buck_one_uvlo, buck_two_uvlo, buck_three_uvlo, thermal_low, thermal_high, upper_current_over;
  logic high_side_switch_one, high_side_switch_two, buck_one_en, buck_two_en, buck_three_en, buck_four_en;
  logic light_load_mode, pwm_gate_on, backup_compare_out, mute_oe, power_good_oe;
  logic thermal_warn_latch, thermal_shutdown_latch;
  logic [31:0] s = 32'h0000a798;
  logic [31:0] r;
  int          miscompares = 0;
  int          tests_run = 0;
  int          hi;
  smfc_note_t  q[$];
  smfc_note_t  e;
  event        sample_ev;
  wire [10:0]  obs = {high_side_switch_one, high_side_switch_two, buck_one_en, buck_two_en, buck_three_en,
                      buck_four_en, light_load_mode, mute_oe, power_good_oe, thermal_warn_latch,
                      thermal_shutdown_latch};
  smfc_top #(.PWM_DIV(4), .LL_COUNT(8), .DEGLITCH_CYC(5), .BLANK_CYC(2)) smfc_top_inst (.*);
  smfc_timer_model #(.HALF(3)) smfc_timer_model_inst (.*);
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string n, input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic chk(input string n, input logic [10:0] m, input logic [10:0] v);
    q.push_back('{n, m, v});
    ->sample_ev;
  endtask
  task automatic wrap_up();
    $display("%0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
    forever
    begin
      @(sample_ev);
      e = q.pop_front();
      check(e.n, obs & e.m, e.v & e.m);
    end
  initial
  begin
    #20000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    {rst_b, switch_enable_in, enable_sync_in, accessory_sense_in, backup_sense_in, switch_supply_ov, thermal_low,
     thermal_high, upper_current_over, buck_one_uvlo, buck_two_uvlo, buck_three_uvlo, feedback_one_fault,
     feedback_two_fault, feedback_three_fault, feedback_four_fault} = '0;
    w(5);
    rst_b = 1'b1;
    {switch_enable_in, enable_sync_in, accessory_sense_in} = 3'h7;
    w(10);
    chk("switches on", 11'h7f0, 11'h7e0);
    switch_enable_in = 1'b0;
    w(8);
    chk("switches off", 11'h600, 11'h000);
    {switch_enable_in, switch_supply_ov} = 2'h3;
    w(8);
    chk("overvoltage cut", 11'h600, 11'h000);
    switch_supply_ov = 1'b0;
    w(2);
    chk("two-stage sync delay", 11'h600, 11'h000);
    w(6);
    chk("overvoltage gone", 11'h600, 11'h600);
    $display("test switches done");
    for (int i = 0; i < 9; i++)
    begin
      r = (i == 8) ? 32'h0 : xs();
      {buck_one_uvlo, buck_two_uvlo, buck_three_uvlo, feedback_one_fault, feedback_two_fault,
       feedback_three_fault, feedback_four_fault} = r[6:0];
      w(8);
      chk("lockout and power good", 11'h1c4, {2'h0, ~r[6:4], 3'h0, |r[2:0], 2'h0});
    end
    $display("test supervision done");
    {accessory_sense_in, enable_sync_in} = 2'h0;
    w(20);
    chk("light load waits", 11'h010, 11'h000);
    w(30);
    chk("light load entered", 11'h010, 11'h010);
    accessory_sense_in = 1'b1;
    w(6);
    chk("light load left", 11'h010, 11'h000);
    enable_sync_in = 1'b1;
    thermal_low = 1'b1;
    w(8);
    chk("warn set", 11'h48a, 11'h082);
    thermal_low = 1'b0;
    w(8);
    chk("warn holds", 11'h48a, 11'h082);
    switch_enable_in = 1'b0;
    w(8);
    switch_enable_in = 1'b1;
    w(8);
    chk("warn cleared", 11'h402, 11'h400);
    thermal_high = 1'b1;
    w(8);
    chk("shutdown set", 11'h4f9, 11'h011);
    {thermal_high, enable_sync_in} = 2'h0;
    w(8);
    enable_sync_in = 1'b1;
    w(8);
    chk("short low keeps", 11'h001, 11'h001);
    enable_sync_in = 1'b0;
    w(80);
    enable_sync_in = 1'b1;
    w(10);
    chk("shutdown cleared", 11'h011, 11'h000);
    $display("test thermal done");
    backup_sense_in = 1'b1;
    w(3);
    backup_sense_in = 1'b0;
    w(12);
    chk("glitch ignored", 11'h008, 11'h000);
    check("backup level after glitch", {10'h0, backup_compare_out}, 11'h000);
    backup_sense_in = 1'b1;
    w(12);
    chk("mute on change", 11'h008, 11'h008);
    check("backup level high", {10'h0, backup_compare_out}, 11'h001);
    w(15);
    backup_sense_in = 1'b0;
    w(30);
    chk("mute extended", 11'h008, 11'h008);
    check("backup level low", {10'h0, backup_compare_out}, 11'h000);
    w(40);
    chk("mute released", 11'h008, 11'h000);
    $display("test mute done");
    upper_current_over = 1'b1;
    w(4);
    hi = 0;
    repeat (40)
    begin
      w(1);
      hi += pwm_gate_on;
    end
    check("blanked pulses", {10'h0, hi >= 16}, 11'h001);
    check("pulse cut", {10'h0, hi < 40}, 11'h001);
    upper_current_over = 1'b0;
    w(10);
    check("gate resumes", {10'h0, pwm_gate_on}, 11'h001);
    $display("test overcurrent done");
    w(2);
    wrap_up();
  end
endmodule
`default_nettype wire
